/* src/option_cfg_pkg.sv */
// Package with option byte layout, reset values and program memory map constants.
package option_cfg_pkg;

	// Width of the combined option word.
	localparam int OPT_W = 16;
	// Value held by an unconfigured part.
	localparam logic [15:0] OPT_BLANK = 16'h0000;
	// Mask of positions that may be written; reserved positions are excluded.
	localparam logic [15:0] OPT_WRITABLE = 16'h03cf;
	// Field positions within the option word.
	localparam int POS_STOP_WDG = 9;
	localparam int POS_BROWNOUT = 8;
	localparam int POS_READ_LOCK = 7;
	localparam int POS_CLK_SRC = 6;
	localparam int POS_NMI_PULL = 3;
	localparam int POS_CNT_PULL = 2;
	localparam int POS_HW_WDG = 1;
	localparam int POS_CLK_GUARD = 0;
	// Program memory vector and code space addresses.
	localparam logic [11:0] ADDR_RESET_VEC = 12'hffe;
	localparam logic [11:0] ADDR_NMI_VEC = 12'hffc;
	localparam logic [11:0] ADDR_IRQ_VEC_LO = 12'hff0;
	localparam logic [11:0] ADDR_IRQ_VEC_HI = 12'hff7;
	localparam logic [11:0] ADDR_RSVD_VEC_LO = 12'hff8;
	localparam logic [11:0] ADDR_RSVD_VEC_HI = 12'hffb;
	localparam logic [11:0] ADDR_USER_END = 12'hf9f;
	localparam logic [11:0] ADDR_USER_START_SMALL = 12'h880;
	localparam logic [11:0] ADDR_USER_START_LARGE = 12'h080;
	// Register offsets on the Avalon slave (word indices; byte address is four times).
	localparam logic [1:0] REG_CONFIG = 2'h0;
	localparam logic [1:0] REG_MEMMAP = 2'h1;
	// Value returned for unmapped or hidden reads.
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_LOAD = 2'b01,
		ST_RUN = 2'b10
	} phase_e;

endpackage : option_cfg_pkg

/* src/option_store_if.sv */
// Interface carrying the option store write port and its stored word.
`timescale 1ns/1ps
interface option_store_if;
	// Write strobe from the programming port.
	logic wr;
	// Word offered for programming.
	logic [15:0] wr_data;
	// Current stored word.
	logic [15:0] word;
	// Pulse when a write came while any writable bit was already programmed.
	logic refused;

	modport ctrl (output wr, output wr_data, input word, input refused);
	modport store (input wr, input wr_data, output word, output refused);
endinterface : option_store_if

/* src/option_store.sv */
// One-time-programmable option word store: bits only go from zero to one, once.
`timescale 1ns/1ps
module option_store (
	// Clock, enable and reset.
	input wire logic clk,
	input wire logic ce,
	input wire logic rst_n,
	// Programming state of the cell array, held outside any reset.
	input wire logic [15:0] cells,
	// Store port.
	option_store_if.store sp
);

	// Programmed image; the cells are nonvolatile so they are loaded after reset.
	logic [15:0] word;
	// Refusal flag for the last write.
	logic refused;

	// Load on the first enabled cycle, then accept a write only while every writable bit is blank.
	logic loaded;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			word <= option_cfg_pkg::OPT_BLANK; // RULE3
			loaded <= 1'b0;
			refused <= 1'b0;
		end else if (ce) begin
			refused <= 1'b0;
			if (!loaded) begin
				word <= cells;
				loaded <= 1'b1;
			end else if (sp.wr) begin
				// Once any writable bit is programmed the word is locked; every further write is refused.
				if ((word & option_cfg_pkg::OPT_WRITABLE) != 16'h0000) begin
					refused <= 1'b1; // RULE2
				end else begin
					word <= sp.wr_data & option_cfg_pkg::OPT_WRITABLE; // RULE2
				end
			end
		end
	end

	assign sp.word = word;
	assign sp.refused = refused;

endmodule : option_store

/* src/option_byte_config_decode.sv */
// Top of the option byte holder and decoder with programming port and status registers.
//
// Overview of operation
// RULE1 - Option bytes have no software address.
// RULE2 - Each option bit programs once only.
// RULE3 - Blank part holds all-zero option bytes.
// RULE4 - Programmer writes zero in reserved bits.
// RULE5 - Stop with watchdog needs bit and NMI high.
// RULE6 - Brown-out detector follows its bit.
// RULE7 - Readout lock blocks external program reads.
// RULE8 - Clock source bit picks crystal or RC.
// RULE9 - NMI pin pull-up follows its bit.
// RULE10 - Counter input pull-up follows its bit.
// RULE11 - Watchdog bit selects hardware or software watchdog.
// RULE12 - Lowest bit enables the clock guard.
// RULE13 - Mask-coded parts: fixed, unreadable configuration.
// RULE14 - Reset vector at top two bytes.
// RULE15 - NMI vector just below reset vector.
// RULE16 - Interrupt vector table; reserved gaps around.
// RULE17 - User code bounds per memory variant.
// RULE18 - Options sampled at reset, held constant.
`timescale 1ns/1ps
// The option word comes from the cells once after reset and is then frozen.
// Software sees decoded settings only; the raw word is for the programmer.
// A fresh burn therefore takes effect at the next reset.
// The programming pins, data word included, and the NMI pin are filtered before use.
module option_byte_config_decode #(
	// One selects the factory mask-coded variant.
	parameter bit MASK_CODED = 1'b0,
	// Option word fixed by the mask in coded parts.
	parameter logic [15:0] MASK_WORD = 16'h0000,
	// One selects the larger program memory variant.
	parameter bit LARGE_MEMORY = 1'b0
) (
	// Clock, enable and reset.
	input wire logic clk,
	input wire logic ce,
	input wire logic rst_n,
	// Programming mode and option write port, from the programming pins.
	input wire logic prog_mode,
	input wire logic prog_wr,
	input wire logic [15:0] prog_wr_data,
	output logic [15:0] prog_rd_data,
	output logic prog_refused,
	// Nonvolatile cell state seen by the option store.
	input wire logic [15:0] option_cells,
	// Live state used for stop permission.
	input wire logic nmi_pin,
	input wire logic watchdog_running,
	// Program memory access checks.
	input wire logic [11:0] fetch_addr,
	input wire logic ext_read_req,
	output logic ext_read_grant,
	output logic addr_is_user_code,
	output logic addr_is_irq_vector,
	output logic addr_is_reserved,
	// Decoded configuration outputs.
	output logic stop_with_watchdog_allow,
	output logic stop_allowed,
	output logic brownout_detect_enable,
	output logic readout_lock,
	output logic clock_source_type_select,
	output logic nmi_pin_pullup_enable,
	output logic counter_input_pin_pullup_enable,
	output logic hardware_watchdog_select,
	output logic clock_guard_enable,
	output logic [11:0] reset_vector_addr,
	output logic [11:0] nmi_vector_addr,
	// Avalon-MM slave.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// Synchronised reset for the rest of the design.
	// First stage of the release chain.
	logic rst_meta;
	// Second stage; all other logic resets on it.
	logic rst_sync_n;

	// Pin synchronisers, three stages each.
	// Programming mode stages.
	logic [2:0] prog_mode_sync;
	// Write strobe stages.
	logic [2:0] prog_wr_sync;
	// Interrupt pin stages.
	logic [2:0] nmi_sync;
	// Write data stages, one word each.
	logic [2:0][15:0] prog_data_sync;

	// Filtered pin levels.
	// Programming mode level.
	logic prog_mode_q;
	// Write strobe level.
	logic prog_wr_q;
	// Interrupt pin level.
	logic nmi_q;
	// Write data word.
	logic [15:0] prog_data_q;

	// Previous filtered write level for edge detection.
	logic prog_wr_prev;

	// Option word latched at reset release and then frozen.
	logic [15:0] cfg;

	// Sequencer state.
	option_cfg_pkg::phase_e phase;
	// Next sequencer state.
	option_cfg_pkg::phase_e next_phase;

	// Bus answer pending flag.
	logic bus_ack;

	// Store connection.
	option_store_if sp_if ();

	// Returns one when an address lies in the inclusive range.
	// Both bounds belong to the range.
	function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	// Two-flop release of the asynchronous reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Assert at once, without the clock.
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			// Release ripples through two edges.
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Pin synchronisers; a level counts once stages two and three agree.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prog_mode_sync <= 3'h0;
			prog_wr_sync <= 3'h0;
			nmi_sync <= 3'h0;
			prog_data_sync <= '0;
			// Pins read as idle until the stages fill.
			prog_mode_q <= 1'b0;
			prog_wr_q <= 1'b0;
			nmi_q <= 1'b0;
			prog_data_q <= 16'h0000;
		end else if (ce) begin
			prog_mode_sync <= {prog_mode_sync[1:0], prog_mode};
			prog_wr_sync <= {prog_wr_sync[1:0], prog_wr};
			nmi_sync <= {nmi_sync[1:0], nmi_pin};
			prog_data_sync <= {prog_data_sync[1:0], prog_wr_data};
			// Each filtered level updates only when the later two stages agree.
			if (prog_mode_sync[1] == prog_mode_sync[2]) begin
				prog_mode_q <= prog_mode_sync[2];
			end
			if (prog_wr_sync[1] == prog_wr_sync[2]) begin
				prog_wr_q <= prog_wr_sync[2];
			end
			if (nmi_sync[1] == nmi_sync[2]) begin
				nmi_q <= nmi_sync[2];
			end
			// Data move with the strobe, so the word is settled when it is taken.
			if (prog_data_sync[1] == prog_data_sync[2]) begin
				prog_data_q <= prog_data_sync[2];
			end
		end
	end

	// Remembers the filtered write level to find its rising edge.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// Idle low, like the pin, so no false edge follows reset.
			prog_wr_prev <= 1'b0;
		end else if (ce) begin
			// One cycle behind the filtered level.
			prog_wr_prev <= prog_wr_q;
		end
	end

	// Writes reach the store only in programming mode and never in mask-coded parts.
	assign sp_if.wr = prog_mode_q && prog_wr_q && !prog_wr_prev && !MASK_CODED; // RULE1 RULE13
	// Reserved positions are dropped; the programmer must keep them zero anyway.
	assign sp_if.wr_data = prog_data_q & option_cfg_pkg::OPT_WRITABLE; // RULE4

	// One-time-programmable store.
	// It resets on the synchronised copy as well.
	option_store u_store (
		.clk(clk),
		.ce(ce),
		.rst_n(rst_sync_n),
		.cells(option_cells),
		.sp(sp_if.store)
	);

	// Sequencer: wait out the store load, sample once, then run.
	always_comb begin
		next_phase = phase;
		// One step per enabled edge, then rest.
		case (phase)
			option_cfg_pkg::ST_RESET: next_phase = option_cfg_pkg::ST_LOAD;
			// The store is loaded by now.
			option_cfg_pkg::ST_LOAD: next_phase = option_cfg_pkg::ST_RUN;
			option_cfg_pkg::ST_RUN: next_phase = option_cfg_pkg::ST_RUN;
			// An unused code restarts the load.
			default: next_phase = option_cfg_pkg::ST_RESET;
		endcase
	end

	// State register.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// Start over on every reset.
			phase <= option_cfg_pkg::ST_RESET;
		end else if (ce) begin
			// Advance only while enabled.
			phase <= next_phase;
		end
	end

	// Configuration is captured once after reset and held until the next reset.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// Blank until the load step.
			cfg <= option_cfg_pkg::OPT_BLANK; // RULE3
		end else if (ce && phase == option_cfg_pkg::ST_LOAD) begin
			// Coded parts ignore the cells.
			cfg <= MASK_CODED ? MASK_WORD : sp_if.word; // RULE18 RULE13
		end
	end

	// Programming port read-back; hidden outside programming mode and in coded parts.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prog_rd_data <= 16'h0000;
			prog_refused <= 1'b0;
			// Nothing shows while in reset.
		end else if (ce) begin
			// Read-back trails the store by a cycle.
			prog_rd_data <= (prog_mode_q && !MASK_CODED) ? sp_if.word : 16'h0000; // RULE1 RULE13
			prog_refused <= sp_if.refused; // RULE2
		end
	end

	// Decoded static configuration outputs and stop permission, registered.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			stop_with_watchdog_allow <= 1'b0;
			stop_allowed <= 1'b0;
			brownout_detect_enable <= 1'b0;
			readout_lock <= 1'b0;
			clock_source_type_select <= 1'b0;
			nmi_pin_pullup_enable <= 1'b0;
			counter_input_pin_pullup_enable <= 1'b0;
			hardware_watchdog_select <= 1'b0;
			clock_guard_enable <= 1'b0;
			// Every feature off while in reset.
		end else if (ce) begin
			// Each output except stop_allowed mirrors one frozen bit.
			stop_with_watchdog_allow <= cfg[option_cfg_pkg::POS_STOP_WDG]; // RULE5
			// Stop is free with the watchdog idle, else needs the bit and NMI high.
			stop_allowed <= !watchdog_running || (cfg[option_cfg_pkg::POS_STOP_WDG] && nmi_q); // RULE5
			brownout_detect_enable <= cfg[option_cfg_pkg::POS_BROWNOUT]; // RULE6
			readout_lock <= cfg[option_cfg_pkg::POS_READ_LOCK]; // RULE7
			clock_source_type_select <= cfg[option_cfg_pkg::POS_CLK_SRC]; // RULE8
			nmi_pin_pullup_enable <= cfg[option_cfg_pkg::POS_NMI_PULL]; // RULE9
			counter_input_pin_pullup_enable <= cfg[option_cfg_pkg::POS_CNT_PULL]; // RULE10
			hardware_watchdog_select <= cfg[option_cfg_pkg::POS_HW_WDG]; // RULE11
			clock_guard_enable <= cfg[option_cfg_pkg::POS_CLK_GUARD]; // RULE12
		end
	end

	// External program reads pass only while the lock is clear.
	// Combinational, so a blocked read never gets a cycle.
	assign ext_read_grant = ext_read_req && !readout_lock; // RULE7

	// Vector addresses are fixed at the top of program memory.
	// They never depend on the option word.
	assign reset_vector_addr = option_cfg_pkg::ADDR_RESET_VEC; // RULE14
	assign nmi_vector_addr = option_cfg_pkg::ADDR_NMI_VEC; // RULE15

	// Program memory region classification.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			addr_is_user_code <= 1'b0;
			addr_is_irq_vector <= 1'b0;
			addr_is_reserved <= 1'b0;
		end else if (ce) begin
			// Flags lag the address by one cycle.
			// Interrupt vector table.
			addr_is_irq_vector <= in_range(fetch_addr, option_cfg_pkg::ADDR_IRQ_VEC_LO,
				option_cfg_pkg::ADDR_IRQ_VEC_HI); // RULE16
			// User code span of this variant.
			addr_is_user_code <= in_range(fetch_addr,
				LARGE_MEMORY ? option_cfg_pkg::ADDR_USER_START_LARGE : option_cfg_pkg::ADDR_USER_START_SMALL,
				option_cfg_pkg::ADDR_USER_END); // RULE17
			// Reserved: below user start, between user end and the table, and the gap above it.
			addr_is_reserved <= (fetch_addr < (LARGE_MEMORY ? option_cfg_pkg::ADDR_USER_START_LARGE
				: option_cfg_pkg::ADDR_USER_START_SMALL))
				|| in_range(fetch_addr, option_cfg_pkg::ADDR_USER_END + 12'h001,
				option_cfg_pkg::ADDR_IRQ_VEC_LO - 12'h001)
				|| in_range(fetch_addr, option_cfg_pkg::ADDR_RSVD_VEC_LO,
				option_cfg_pkg::ADDR_RSVD_VEC_HI); // RULE16 RULE17
		end
	end

	// Bus answer: every access waits one cycle, then completes.
	// Low exactly in the cycle after the request was taken.
	assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

	// Acknowledge flop, cleared after each completed access.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// No access is pending after reset.
			bus_ack <= 1'b0;
		end else if (ce) begin
			// Set in the wait cycle, cleared in the answer cycle.
			bus_ack <= (avs_read || avs_write) && !bus_ack;
		end
	end

	// Read data: decoded settings and memory variant; option bytes themselves have no address.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// Reads zero until the first access.
			avs_readdata <= option_cfg_pkg::READ_ZERO;
		end else if (ce && avs_read && !bus_ack) begin
			// Taken in the wait cycle, so data stand when waitrequest drops.
			if (avs_address[3:2] == option_cfg_pkg::REG_CONFIG && avs_address[1:0] == 2'h0) begin
				avs_readdata <= {22'h000000, phase == option_cfg_pkg::ST_RUN, stop_allowed,
					brownout_detect_enable, readout_lock, clock_source_type_select,
					nmi_pin_pullup_enable, counter_input_pin_pullup_enable,
					hardware_watchdog_select, clock_guard_enable, stop_with_watchdog_allow}; // RULE1
			end else if (avs_address[3:2] == option_cfg_pkg::REG_MEMMAP && avs_address[1:0] == 2'h0) begin
				avs_readdata <= {8'h00, LARGE_MEMORY ? option_cfg_pkg::ADDR_USER_START_LARGE
					: option_cfg_pkg::ADDR_USER_START_SMALL, option_cfg_pkg::ADDR_USER_END};
			end else begin
				// Unmapped or misaligned reads give zero.
				avs_readdata <= option_cfg_pkg::READ_ZERO;
			end
		end
	end

endmodule : option_byte_config_decode

/* testbench/option_byte_config_decode_props.sv */
// Assertion checker for the option decoder top ports.
`timescale 1ns/1ps
module option_byte_config_decode_props #(
	parameter bit LARGE_MEMORY = 1'b0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Watched inputs.
	input wire logic prog_mode,
	input wire logic [15:0] option_cells,
	input wire logic watchdog_running,
	input wire logic [11:0] fetch_addr,
	input wire logic ext_read_req,
	input wire logic avs_read,
	// Watched outputs.
	input wire logic [15:0] prog_rd_data,
	input wire logic ext_read_grant,
	input wire logic addr_is_user_code,
	input wire logic addr_is_irq_vector,
	input wire logic addr_is_reserved,
	input wire logic stop_with_watchdog_allow,
	input wire logic stop_allowed,
	input wire logic brownout_detect_enable,
	input wire logic readout_lock,
	input wire logic clock_source_type_select,
	input wire logic nmi_pin_pullup_enable,
	input wire logic counter_input_pin_pullup_enable,
	input wire logic hardware_watchdog_select,
	input wire logic clock_guard_enable,
	input wire logic [11:0] reset_vector_addr,
	input wire logic [11:0] nmi_vector_addr,
	input wire logic avs_waitrequest
);
	// Cycles since reset release; outputs count as settled from fifteen on.
	logic [3:0] age;
	// First user code address of the chosen memory variant.
	logic [11:0] ustart;
	// Decoded outputs in option word bit order.
	logic [7:0] cfg;
	assign ustart = LARGE_MEMORY ? option_cfg_pkg::ADDR_USER_START_LARGE : option_cfg_pkg::ADDR_USER_START_SMALL;
	assign cfg = {stop_with_watchdog_allow, brownout_detect_enable, readout_lock, clock_source_type_select,
		nmi_pin_pullup_enable, counter_input_pin_pullup_enable, hardware_watchdog_select, clock_guard_enable};
	// The counter saturates, so it marks settled state until the next reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			age <= 4'h0;
		end else if (age != 4'hf) begin
			age <= age + 4'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// A bus request waits one cycle, then is answered.
	sequence wait_then_answer;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	bus_answer_a: assert property ($rose(avs_read) |-> wait_then_answer) else $error("bus answer timing wrong");
	decode_map_a: assert property (age == 4'hf |-> cfg == {option_cells[9:6], option_cells[3:0]})
		else $error("decoded options differ from cells");
	grant_lock_a: assert property (ext_read_grant == (ext_read_req && !readout_lock))
		else $error("external read grant ignores lock");
	stop_free_a: assert property (age == 4'hf && !watchdog_running |=> stop_allowed)
		else $error("stop refused with watchdog idle");
	stop_block_a: assert property (age == 4'hf && watchdog_running && !stop_with_watchdog_allow |=> !stop_allowed)
		else $error("stop allowed with watchdog running");
	vector_addr_a: assert property (age == 4'hf |-> reset_vector_addr == 12'hffe && nmi_vector_addr == 12'hffc)
		else $error("vector address wrong");
	hidden_word_a: assert property (!prog_mode [*6] |-> prog_rd_data == 16'h0000)
		else $error("option word visible outside programming");
	once_only_a: assert property (prog_rd_data != 16'h0000 |=> prog_rd_data == 16'h0000 || $stable(prog_rd_data))
		else $error("programmed word changed");
	user_span_a: assert property (age == 4'hf |=> addr_is_user_code ==
		($past(fetch_addr) >= ustart && $past(fetch_addr) <= 12'hf9f)) else $error("user code flag wrong");
	irq_span_a: assert property (age == 4'hf |=> addr_is_irq_vector ==
		($past(fetch_addr) >= 12'hff0 && $past(fetch_addr) <= 12'hff7)) else $error("vector table flag wrong");
	rsvd_span_a: assert property (age == 4'hf |=> addr_is_reserved ==
		!(addr_is_user_code || addr_is_irq_vector || $past(fetch_addr) >= 12'hffc)) else $error("reserved flag wrong");
endmodule : option_byte_config_decode_props
bind option_byte_config_decode option_byte_config_decode_props #(.LARGE_MEMORY(LARGE_MEMORY)) u_props (.*);

/* testbench/option_prog_tool.sv */
// Model of the external programming tool on the option write pins.
`timescale 1ns/1ps
module option_prog_tool (
	// Clock.
	input wire logic clk,
	// Programming pins.
	output logic prog_mode,
	output logic prog_wr,
	output logic [15:0] prog_wr_data
);
	// Pins idle outside programming; data lines carry a scrambled value.
	initial begin
		prog_mode = 1'b0;
		prog_wr = 1'b0;
		prog_wr_data = 16'ha5a5;
	end
	// Enters or leaves programming mode and lets the pin filter settle.
	task automatic set_mode(input logic m);
		@(posedge clk);
		prog_mode <= m;
		repeat (8) @(posedge clk);
	endtask : set_mode
	// One write attempt; reserved positions go out as zero while the strobe is high.
	task automatic burn(input logic [15:0] w);
		@(posedge clk);
		prog_wr_data <= w & 16'h03cf;
		prog_wr <= 1'b1;
		repeat (8) @(posedge clk);
		prog_wr <= 1'b0;
		repeat (8) @(posedge clk);
		// Released data lines stop showing the written word.
		prog_wr_data <= ~(w & 16'h03cf);
	endtask : burn
endmodule : option_prog_tool

/* testbench/test_option_byte_config_decode.sv */
// Self-checking bench for the option byte decoder.
`timescale 1ns/1ps
module test_option_byte_config_decode;
	// Driven inputs.
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] option_cells = 16'h0000;
	logic nmi_pin = 1'b0;
	logic watchdog_running = 1'b0;
	logic [11:0] fetch_addr = 12'h000;
	logic ext_read_req = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	// Tool pins and observed outputs.
	logic prog_mode, prog_wr, prog_refused, ext_read_grant, stop_allowed, avs_waitrequest;
	logic [15:0] prog_wr_data, prog_rd_data;
	logic [31:0] avs_readdata;
	wire [7:0] cfg;
	wire [2:0] fl;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int refusals = 0;
	// Clock of 10 ns period.
	always #5 clk = ~clk;
	option_prog_tool u_tool (.clk(clk), .prog_mode(prog_mode), .prog_wr(prog_wr), .prog_wr_data(prog_wr_data));
	option_byte_config_decode u_dut (.clk(clk), .ce(1'b1), .rst_n(rst_n), .prog_mode(prog_mode), .prog_wr(prog_wr),
		.prog_wr_data(prog_wr_data), .prog_rd_data(prog_rd_data), .prog_refused(prog_refused),
		.option_cells(option_cells), .nmi_pin(nmi_pin), .watchdog_running(watchdog_running),
		.fetch_addr(fetch_addr), .ext_read_req(ext_read_req), .ext_read_grant(ext_read_grant),
		.addr_is_user_code(fl[2]), .addr_is_irq_vector(fl[1]), .addr_is_reserved(fl[0]),
		.stop_with_watchdog_allow(cfg[7]), .stop_allowed(stop_allowed), .brownout_detect_enable(cfg[6]),
		.readout_lock(cfg[5]), .clock_source_type_select(cfg[4]), .nmi_pin_pullup_enable(cfg[3]),
		.counter_input_pin_pullup_enable(cfg[2]), .hardware_watchdog_select(cfg[1]),
		.clock_guard_enable(cfg[0]), .reset_vector_addr(), .nmi_vector_addr(), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	// Counts refusal pulses of the option store.
	always @(posedge clk) if (prog_refused === 1'b1) refusals++;
	// Cuts a hang short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("ERROR cycles expected below 20000 seen %0d", cycles);
			give_verdict();
		end
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	// Compares one value and counts it.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Resets with a given cell content and waits for the outputs to settle.
	task automatic do_reset(input logic [15:0] cells);
		@(posedge clk);
		rst_n <= 1'b0;
		option_cells <= cells;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (16) @(posedge clk);
	endtask : do_reset
	// One bus cycle held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= 32'hffff_ffff;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	// Blank part: options off, registers read, a write ignored, unmapped reads zero.
	task automatic t_blank();
		logic [31:0] d;
		do_reset(16'h0000);
		chk("options", 32'h0, {24'h0, cfg});
		bus(1'b1, 4'h0, d);
		bus(1'b0, 4'h0, d);
		chk("status", 32'h0000_0300, d);
		bus(1'b0, 4'h4, d);
		chk("map", 32'h0088_0f9f, d);
		bus(1'b0, 4'h8, d);
		chk("unmapped", 32'h0, d);
		$display("t_blank done");
	endtask : t_blank
	// Each writable position alone, with the external read grant beside it.
	task automatic t_decode();
		logic [15:0] w;
		for (int i = 0; i < 10; i++) begin
			if (i == 4 || i == 5) continue;
			w = 16'h0001 << i;
			do_reset(w);
			chk("decode", {24'h0, w[9:6], w[3:0]}, {24'h0, cfg});
			ext_read_req <= 1'b1;
			@(negedge clk);
			chk("grant", {31'h0, i != 7}, {31'h0, ext_read_grant});
			@(posedge clk);
			ext_read_req <= 1'b0;
		end
		$display("t_decode done");
	endtask : t_decode
	// Stop permission with the watchdog running.
	task automatic t_stop();
		do_reset(16'h0200);
		watchdog_running <= 1'b1;
		repeat (6) @(posedge clk);
		chk("stop nmi low", 32'h0, {31'h0, stop_allowed});
		nmi_pin <= 1'b1;
		repeat (6) @(posedge clk);
		chk("stop nmi high", 32'h1, {31'h0, stop_allowed});
		do_reset(16'h0000);
		chk("stop option off", 32'h0, {31'h0, stop_allowed});
		watchdog_running <= 1'b0;
		nmi_pin <= 1'b0;
		$display("t_stop done");
	endtask : t_stop
	// One burn, a refused second burn, hidden word, new options after reset.
	task automatic t_prog();
		do_reset(16'h0000);
		refusals = 0;
		u_tool.set_mode(1'b1);
		u_tool.burn(16'hfcc5);
		chk("burned word", 32'h00c5, {16'h0, prog_rd_data});
		chk("options held", 32'h0, {24'h0, cfg});
		u_tool.burn(16'h0002);
		chk("refusals", 32'h1, refusals);
		chk("word kept", 32'h00c5, {16'h0, prog_rd_data});
		u_tool.set_mode(1'b0);
		chk("hidden word", 32'h0, {16'h0, prog_rd_data});
		do_reset(16'h00c5);
		chk("options after reset", 32'h35, {24'h0, cfg});
		$display("t_prog done");
	endtask : t_prog
	// Program memory regions at their boundaries.
	task automatic t_fetch();
		logic [11:0] a [9] = '{12'h07f, 12'h87f, 12'h880, 12'hf9f, 12'hfa0, 12'hff0, 12'hff7, 12'hff8, 12'hffe};
		logic [2:0] e [9] = '{3'b001, 3'b001, 3'b100, 3'b100, 3'b001, 3'b010, 3'b010, 3'b001, 3'b000};
		foreach (a[i]) begin
			@(posedge clk);
			fetch_addr <= a[i];
			@(posedge clk);
			@(negedge clk);
			chk("fetch flags", {29'h0, e[i]}, {29'h0, fl});
		end
		$display("t_fetch done");
	endtask : t_fetch
	// Main sequence.
	initial begin
		t_blank();
		t_decode();
		t_stop();
		t_prog();
		t_fetch();
		give_verdict();
	end
endmodule : test_option_byte_config_decode
